// file: bench/pfc_fir_config_asserts.sv
// Concurrent property checker for the FIR configuration register block
`timescale 1ns/1ns

module pfc_fir_config_chk
	import pfc_pkg::*;
#(
	parameter int NTAPS = PFC_TAPS
) (
	input wire logic                             pclk,
	input wire logic                             presetn,
	input wire logic                             psel,
	input wire logic                             penable,
	input wire logic                             pwrite,
	input wire logic [PFC_ADDR_W-1:0]            paddr,
	input wire logic [31:0]                      pwdata,
	input wire logic [31:0]                      prdata,
	input wire logic                             pready,
	input wire logic                             pslverr,
	input wire logic                             xfer_gpio,
	input wire logic [2:0]                       i_path_filter_sel,
	input wire logic [2:0]                       q_path_filter_sel,
	input wire logic [5:0]                       half_cplx_tap_delay,
	input wire logic [NTAPS-1:0][PFC_COEF_W-1:0] x_coef_i_path,
	input wire logic [NTAPS-1:0][PFC_COEF_W-1:0] y_coef_i_path,
	input wire logic [NTAPS-1:0][PFC_COEF_W-1:0] x_coef_q_path,
	input wire logic [NTAPS-1:0][PFC_COEF_W-1:0] y_coef_q_path,
	input wire logic                             coef_xfer,
	input wire logic                             filter_ready,
	input wire logic                             mode_pair_ok
);
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic bad(input logic [2:0] a, input logic [2:0] b);
		return (a == 3'h5 && b != 3'h5) || (a == 3'h6 && b != 3'h2) || (a == 3'h7 && b != 3'h0);
	endfunction : bad

	logic acc;
	logic legal;
	logic mode_wr;
	assign acc     = psel && penable && pready;
	assign legal   = !(bad(i_path_filter_sel, q_path_filter_sel) ||
		bad(q_path_filter_sel, i_path_filter_sel));
	assign mode_wr = acc && pwrite && paddr[13:2] == PFC_IDX_MODE;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	property p_mode_rsv;
		acc && !pwrite && paddr[13:2] == PFC_IDX_MODE |-> prdata[31:3] == 29'h0;
	endproperty
	a_mode_rsv: assert property (p_mode_rsv) else $error("mode readback reserved bits set");

	property p_gain_rsv;
		acc && !pwrite && paddr[13:2] == PFC_IDX_GAIN |-> prdata[31:8] == 24'h0 && !prdata[7] && !prdata[3];
	endproperty
	a_gain_rsv: assert property (p_gain_rsv) else $error("gain readback reserved bits set");

	property p_delay_max;
		half_cplx_tap_delay <= PFC_DELAY_MAX;
	endproperty
	a_delay_max: assert property (p_delay_max) else $error("tap delay above limit");

	property p_coef_hold;
		!coef_xfer |=> $stable(x_coef_i_path) && $stable(y_coef_i_path) && $stable(x_coef_q_path)
			&& $stable(y_coef_q_path) && $stable(half_cplx_tap_delay);
	endproperty
	a_coef_hold: assert property (p_coef_hold) else $error("active bank changed without transfer");

	property p_xfer_cause;
		$rose(coef_xfer) |-> $past(acc && pwrite && paddr[13:2] == PFC_IDX_XFER &&
			pwdata[7:0] == PFC_XFER_GO) || ($past(xfer_gpio) && !$past(xfer_gpio, 2));
	endproperty
	a_xfer_cause: assert property (p_xfer_cause) else $error("transfer pulse without trigger");

	property p_pair;
		($stable(i_path_filter_sel) && $stable(q_path_filter_sel)) [*2] |-> mode_pair_ok == legal;
	endproperty
	a_pair: assert property (p_pair) else $error("mode pair flag wrong");

	property p_ready_wait;
		$fell(filter_ready) |-> ($past(mode_wr) && !filter_ready) ##1 !filter_ready [*7];
	endproperty
	a_ready_wait: assert property (p_ready_wait) else $error("power-up wait too short");

	property p_no_corrupt;
		!mode_pair_ok && !coef_xfer |=> $stable(x_coef_q_path) && $stable(y_coef_q_path);
	endproperty
	a_no_corrupt: assert property (p_no_corrupt) else $error("illegal pair touched banks");

	c_xfer: cover property ($rose(coef_xfer));
	c_bad_pair: cover property (!mode_pair_ok);
	c_err: cover property (acc && pslverr);
endmodule : pfc_fir_config_chk

bind pfc_fir_config pfc_fir_config_chk #(.NTAPS(NTAPS)) u_chk (.pclk, .presetn, .psel, .penable,
	.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .xfer_gpio, .i_path_filter_sel,
	.q_path_filter_sel, .half_cplx_tap_delay, .x_coef_i_path, .y_coef_i_path, .x_coef_q_path,
	.y_coef_q_path, .coef_xfer, .filter_ready, .mode_pair_ok);

// file: bench/pfc_xfer_host.sv
// Host-side model driving the transfer GPIO pin
`timescale 1ns/1ns

module pfc_xfer_host (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic go,
	output logic      xfer_gpio
);
	logic [1:0] cnt_q;
	logic [1:0] cnt_d;

	// Pin held high three cycles so only one rising edge is seen
	always_comb begin
		cnt_d = cnt_q;
		if (go) begin
			cnt_d = 2'h3;
		end else if (cnt_q != 2'h0) begin
			cnt_d = cnt_q - 2'h1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= 2'h0;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	assign xfer_gpio = (cnt_q != 2'h0);
endmodule : pfc_xfer_host

// file: bench/testbench.sv
// Self-checking bench for the FIR configuration register block
`timescale 1ns/1ns

module testbench
	import pfc_pkg::*;
;
	logic                                   pclk, presetn, pce, psel, penable, pwrite, gpio_go;
	logic                                   pready, pslverr, xfer_gpio, err_seen;
	logic                                   coef_xfer, filter_ready, mode_pair_ok;
	logic [PFC_ADDR_W-1:0]                  paddr;
	logic [31:0]                            pwdata, prdata, rdata_seen;
	logic [2:0]                             i_path_filter_sel, q_path_filter_sel;
	pfc_path_cfg_type                       i_path_cfg, q_path_cfg;
	logic [5:0]                             half_cplx_tap_delay;
	logic [PFC_TAPS-1:0][PFC_COEF_W-1:0]    x_coef_i_path, y_coef_i_path;
	logic [PFC_TAPS-1:0][PFC_COEF_W-1:0]    x_coef_q_path, y_coef_q_path;
	logic [2:0]                             gc [5] = '{3'h6, 3'h7, 3'h0, 3'h1, 3'h2};
	logic [2:0]                             il [5] = '{3'h0, 3'h2, 3'h5, 3'h6, 3'h7};
	logic [2:0]                             ql [3] = '{3'h0, 3'h2, 3'h5};
	int                                     miscompares, check_count;

	pfc_fir_config #(.NTAPS(PFC_TAPS)) dut (.pclk, .presetn, .pce, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .xfer_gpio, .i_path_filter_sel,
		.q_path_filter_sel, .i_path_cfg, .q_path_cfg, .half_cplx_tap_delay, .x_coef_i_path,
		.y_coef_i_path, .x_coef_q_path, .y_coef_q_path, .coef_xfer, .filter_ready, .mode_pair_ok);
	pfc_xfer_host host (.pclk, .presetn, .go(gpio_go), .xfer_gpio);

	always #25 pclk = ~pclk;

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	function automatic logic bad(input logic [2:0] a, input logic [2:0] b);
		return (a == 3'h5 && b != 3'h5) || (a == 3'h6 && b != 3'h2) || (a == 3'h7 && b != 3'h0);
	endfunction : bad

	function automatic logic [15:0] cf(input int p, input logic y, input int n);
		return {y, p[1:0], n[4:0], 8'h5a ^ n[7:0]};
	endfunction : cf

	task automatic end_sim();
		if (miscompares == 0 && check_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : end_sim

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Request held until pready is sampled high; the slave sets the pace
	task automatic apb(input logic w, input logic [11:0] idx, input logic [7:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			miscompares++;
			end_sim();
		end else begin
			rdata_seen = prdata;
			err_seen = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask : apb

	task automatic wr(input logic [11:0] idx, input logic [7:0] d);
		apb(1'b1, idx, d);
	endtask : wr

	task automatic rdchk(input logic [11:0] idx, input logic [31:0] exp);
		apb(1'b0, idx, 8'h00);
		chk(rdata_seen, exp);
	endtask : rdchk

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		logic [15:0] c;
		pclk = 1'b0;
		presetn = 1'b0;
		pce = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		gpio_go = 1'b0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		rdchk(PFC_IDX_GAIN, 32'h0);
		wr(PFC_IDX_GAIN, 8'h11);
		@(posedge pclk);
		chk(32'(i_path_cfg), 32'h0);
		wr(PFC_IDX_DEVSEL, 8'(PFC_SEL_I));
		for (int m = 0; m < 8; m++) begin
			if (m == 3) continue;
			wr(PFC_IDX_MODE, {5'h1f, 3'(m)});
			rdchk(PFC_IDX_MODE, 32'(m));
			chk(32'(i_path_filter_sel), 32'(m));
		end
		for (int k = 0; k < 5; k++) begin
			wr(PFC_IDX_GAIN, {1'b1, gc[(k + 2) % 5], 1'b1, gc[k]});
			rdchk(PFC_IDX_GAIN, {25'h0, gc[(k + 2) % 5], 1'b0, gc[k]});
			chk(32'({i_path_cfg.y_gain, i_path_cfg.x_gain}), {26'h0, gc[(k + 2) % 5], gc[k]});
		end
		for (int a = 0; a < 5; a++) begin
			for (int b = 0; b < 3; b++) begin
				wr(PFC_IDX_DEVSEL, 8'(PFC_SEL_I));
				wr(PFC_IDX_MODE, 8'(il[a]));
				wr(PFC_IDX_DEVSEL, 8'(PFC_SEL_Q));
				wr(PFC_IDX_MODE, 8'(ql[b]));
				repeat (3) @(posedge pclk);
				chk(32'({i_path_filter_sel, q_path_filter_sel}), 32'({il[a], ql[b]}));
				chk(32'(mode_pair_ok), 32'(!(bad(il[a], ql[b]) || bad(ql[b], il[a]))));
			end
		end
		wr(PFC_IDX_MODE, 8'(PFC_MODE_CASC));
		wr(PFC_IDX_DEVSEL, 8'(PFC_SEL_I));
		wr(PFC_IDX_MODE, 8'(PFC_MODE_CASC));
		repeat (2) @(posedge pclk);
		chk(32'(filter_ready), 32'h0);
		repeat (85) @(posedge pclk);
		chk(32'(filter_ready), 32'h0);
		repeat (20) @(posedge pclk);
		chk(32'(filter_ready), 32'h1);
		chk(32'(q_path_cfg), {23'h0, PFC_MODE_CASC, 6'h00});
		for (int p = 1; p < 3; p++) begin
			wr(PFC_IDX_DEVSEL, 8'(p));
			for (int n = 0; n < PFC_TAPS; n++) begin
				c = cf(p, 1'b0, n);
				wr(PFC_IDX_XCOEF + 12'(2 * n), c[7:0]);
				wr(PFC_IDX_XCOEF + 12'(2 * n + 1), c[15:8]);
				c = cf(p, 1'b1, n);
				wr(PFC_IDX_YCOEF + 12'(2 * n), c[7:0]);
				wr(PFC_IDX_YCOEF + 12'(2 * n + 1), c[15:8]);
			end
		end
		rdchk(PFC_IDX_YCOEF_LO, 32'(c[15:8]));
		chk(32'(y_coef_q_path[23]), 32'h0);
		wr(PFC_IDX_XFER, 8'h02);
		repeat (3) @(posedge pclk);
		chk(32'(x_coef_i_path[0]), 32'h0);
		wr(PFC_IDX_XFER, PFC_XFER_GO);
		@(posedge pclk);
		chk(32'(coef_xfer), 32'h1);
		repeat (2) @(posedge pclk);
		for (int n = 0; n < PFC_TAPS; n++) begin
			chk(32'(x_coef_i_path[n]), 32'(cf(1, 1'b0, n)));
			chk(32'(y_coef_i_path[n]), 32'(cf(1, 1'b1, n)));
			chk(32'(x_coef_q_path[n]), 32'(cf(2, 1'b0, n)));
			chk(32'(y_coef_q_path[n]), 32'(cf(2, 1'b1, n)));
		end
		wr(PFC_IDX_DEVSEL, 8'(PFC_SEL_I));
		wr(PFC_IDX_DELAY, 8'h30);
		wr(PFC_IDX_XCOEF, 8'h11);
		wr(PFC_IDX_MODE, 8'(PFC_MODE_FCPX));
		repeat (3) @(posedge pclk);
		chk(32'(mode_pair_ok), 32'h0);
		chk(32'(x_coef_i_path[0]), 32'(cf(1, 1'b0, 0)));
		gpio_go <= 1'b1;
		@(posedge pclk);
		gpio_go <= 1'b0;
		repeat (6) @(posedge pclk);
		chk(32'(half_cplx_tap_delay), 32'h2f);
		c = cf(1, 1'b0, 0);
		chk(32'(x_coef_i_path[0]), {16'h0, c[15:8], 8'h11});
		apb(1'b0, 12'hf31, 8'h00);
		chk(32'(err_seen), 32'h1);
		chk(rdata_seen, 32'h0);
		end_sim();
	end
endmodule : testbench

// file: design/pfc_coef_bank.sv
// Shadow and active X/Y coefficient storage for one filter path
`timescale 1ns/1ns

module pfc_coef_bank
	import pfc_pkg::*;
#(
	parameter int NTAPS = PFC_TAPS
) (
	input  wire logic                             pclk,
	input  wire logic                             presetn,
	input  wire logic                             pce,
	input  wire logic                             wr_en,
	input  wire logic                             wr_y,
	input  wire logic                             wr_hi,
	input  wire logic [PFC_TAP_W-1:0]             wr_tap,
	input  wire logic [7:0]                       wr_byte,
	input  wire logic                             xfer,
	output logic      [7:0]                       rd_byte,
	output logic      [NTAPS-1:0][PFC_COEF_W-1:0] act_x_q,
	output logic      [NTAPS-1:0][PFC_COEF_W-1:0] act_y_q
);

	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	logic [NTAPS-1:0][PFC_COEF_W-1:0] sh_x_q, sh_x_d;
	logic [NTAPS-1:0][PFC_COEF_W-1:0] sh_y_q, sh_y_d;
	logic [NTAPS-1:0][PFC_COEF_W-1:0] act_x_d, act_y_d;
	logic [PFC_COEF_W-1:0]            rd_word;

	always_comb begin
		sh_x_d  = sh_x_q;
		sh_y_d  = sh_y_q;
		if (wr_en && !wr_y) begin
			if (wr_hi) sh_x_d[wr_tap][15:8] = wr_byte;
			else sh_x_d[wr_tap][7:0] = wr_byte;
		end
		if (wr_en && wr_y) begin
			if (wr_hi) sh_y_d[wr_tap][15:8] = wr_byte;
			else sh_y_d[wr_tap][7:0] = wr_byte;
		end
		// Active taps change only on transfer, so the filter never sees a half-written set
		act_x_d = xfer ? sh_x_q : act_x_q;
		act_y_d = xfer ? sh_y_q : act_y_q;
		rd_word = wr_y ? sh_y_q[wr_tap] : sh_x_q[wr_tap];
		rd_byte = wr_hi ? rd_word[15:8] : rd_word[7:0];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sh_x_q  <= '0;
			sh_y_q  <= '0;
			act_x_q <= '0;
			act_y_q <= '0;
		end else if (pce) begin
			sh_x_q  <= sh_x_d;
			sh_y_q  <= sh_y_d;
			act_x_q <= act_x_d;
			act_y_q <= act_y_d;
		end
	end

endmodule : pfc_coef_bank

// file: design/pfc_fir_config.sv
// APB register block configuring the I and Q programmable FIR filters
//
// Overview of operation
// - Each path mode register holds a 3-bit mode; 000 bypasses the filters.
// - Mode 001 is one real 24-tap filter on the X bank only.
// - Mode 010 is a real 48-tap filter, X taps 0-23, Y taps 24-47.
// - Mode 100 cascades two 24-tap filters, X stage then Y stage.
// - Mode 101 is full complex; the other path must also be 101.
// - Mode 110 is half complex with delay line; other path must be 010.
// - Mode 111 is a real 96-tap filter; other path must be 000.
// - Gain register: Y gain bits 6:4, X gain bits 2:0, 6 dB steps.
// - Coefficients are signed Q1.15 sixteen-bit values.
// - X bank: low byte at 0x0E00+2n, high byte at the next index.
// - Y bank from 0x0F00, two bytes per coefficient.
// - Index half_complex_tap_delay sets I path tapped delay 0 to 47 in half complex.
// - Coefficients go to shadow; transfer register or GPIO edge applies them.
`timescale 1ns/1ns

module pfc_fir_config
	import pfc_pkg::*;
#(
	parameter int NTAPS = PFC_TAPS
) (
	input  wire logic                             pclk,
	input  wire logic                             presetn,
	input  wire logic                             pce,
	input  wire logic                             psel,
	input  wire logic                             penable,
	input  wire logic                             pwrite,
	input  wire logic [PFC_ADDR_W-1:0]            paddr,
	input  wire logic [31:0]                      pwdata,
	output logic      [31:0]                      prdata,
	output logic                                  pready,
	output logic                                  pslverr,
	input  wire logic                             xfer_gpio,
	output logic      [2:0]                       i_path_filter_sel,
	output logic      [2:0]                       q_path_filter_sel,
	output pfc_path_cfg_type                      i_path_cfg,
	output pfc_path_cfg_type                      q_path_cfg,
	output logic      [5:0]                       half_cplx_tap_delay,
	output logic      [NTAPS-1:0][PFC_COEF_W-1:0] x_coef_i_path,
	output logic      [NTAPS-1:0][PFC_COEF_W-1:0] y_coef_i_path,
	output logic      [NTAPS-1:0][PFC_COEF_W-1:0] x_coef_q_path,
	output logic      [NTAPS-1:0][PFC_COEF_W-1:0] y_coef_q_path,
	output logic                                  coef_xfer,
	output logic                                  filter_ready,
	output logic                                  mode_pair_ok
);

	// ----------------------------------------------------------------
	// Functions
	// ----------------------------------------------------------------
	function automatic pfc_reg_type reg_kind(input logic [PFC_IDX_W-1:0] idx);
		if (idx == PFC_IDX_DEVSEL) return PFC_REG_DEVSEL;
		if (idx == PFC_IDX_XFER) return PFC_REG_XFER;
		if (idx == PFC_IDX_MODE) return PFC_REG_MODE;
		if (idx == PFC_IDX_GAIN) return PFC_REG_GAIN;
		if (idx == PFC_IDX_STATUS) return PFC_REG_STATUS;
		if (idx >= PFC_IDX_XCOEF && idx <= PFC_IDX_XCOEF_LO) return PFC_REG_XCOEF;
		if (idx >= PFC_IDX_YCOEF && idx <= PFC_IDX_YCOEF_LO) return PFC_REG_YCOEF;
		if (idx == PFC_IDX_DELAY) return PFC_REG_DELAY;
		return PFC_REG_NONE;
	endfunction : reg_kind

	// Whether the mode of one path is compatible with the mode of the other
	function automatic logic pair_legal(input logic [2:0] own, input logic [2:0] other);
		case (own)
			PFC_MODE_FCPX: return other == PFC_MODE_FCPX;
			PFC_MODE_HCPX: return other == PFC_MODE_R48;
			PFC_MODE_R96: return other == PFC_MODE_BYP;
			PFC_MODE_BYP, PFC_MODE_R24, PFC_MODE_R48, PFC_MODE_CASC: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction : pair_legal

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [1:0]              devsel_q, devsel_d;
	pfc_path_cfg_type        i_cfg_q, i_cfg_d;
	pfc_path_cfg_type        q_cfg_q, q_cfg_d;
	logic [5:0]              sh_delay_q, sh_delay_d;
	logic [5:0]              act_delay_q, act_delay_d;
	logic                    xfer_q, xfer_d;
	logic                    gpio_prev_q, gpio_prev_d;
	logic [PFC_PWRUP_W-1:0]  pwrup_cnt_q, pwrup_cnt_d;
	logic                    ready_q, ready_d;
	logic                    pair_ok_q, pair_ok_d;
	logic                    pready_q, pready_d;
	logic                    pslverr_q, pslverr_d;
	logic [31:0]             prdata_q, prdata_d;

	logic [PFC_IDX_W-1:0]    idx;
	pfc_reg_type             kind;
	logic                    aligned;
	logic                    access;
	logic                    commit;
	logic                    coef_wr;
	logic                    coef_y;
	logic                    coef_hi;
	logic [PFC_TAP_W-1:0]    coef_tap;
	logic [PFC_IDX_W-1:0]    coef_off;
	logic [7:0]              rd_byte_i, rd_byte_q;
	logic [7:0]              rd_byte;
	logic [7:0]              wbyte;

	// ----------------------------------------------------------------
	// Address decode and coefficient banks
	// ----------------------------------------------------------------
	assign idx      = paddr[PFC_ADDR_W-1:2];
	assign aligned  = paddr[1:0] == 2'h0;
	assign kind     = aligned ? reg_kind(idx) : PFC_REG_NONE;
	assign access   = psel && penable && !pready_q;
	assign commit   = psel && penable && pready_q && pwrite && !pslverr_q;
	assign wbyte    = pwdata[7:0];
	assign coef_y   = kind == PFC_REG_YCOEF;
	assign coef_off = idx - (coef_y ? PFC_IDX_YCOEF : PFC_IDX_XCOEF);
	assign coef_tap = coef_off[PFC_TAP_W:1];
	assign coef_hi  = idx[0];
	assign coef_wr  = commit && (kind == PFC_REG_XCOEF || coef_y);

	// Stored words are plain bits; the filter reads them as signed Q1.15
	pfc_coef_bank #(
		.NTAPS   (NTAPS)
	) u_bank_i (
		.pclk    (pclk),
		.presetn (presetn),
		.pce     (pce),
		.wr_en   (coef_wr && devsel_q[0]),
		.wr_y    (coef_y),
		.wr_hi   (coef_hi),
		.wr_tap  (coef_tap),
		.wr_byte (wbyte),
		.xfer    (xfer_q),
		.rd_byte (rd_byte_i),
		.act_x_q (x_coef_i_path),
		.act_y_q (y_coef_i_path)
	);

	pfc_coef_bank #(
		.NTAPS   (NTAPS)
	) u_bank_q (
		.pclk    (pclk),
		.presetn (presetn),
		.pce     (pce),
		.wr_en   (coef_wr && devsel_q[1]),
		.wr_y    (coef_y),
		.wr_hi   (coef_hi),
		.wr_tap  (coef_tap),
		.wr_byte (wbyte),
		.xfer    (xfer_q),
		.rd_byte (rd_byte_q),
		.act_x_q (x_coef_q_path),
		.act_y_q (y_coef_q_path)
	);

	// ----------------------------------------------------------------
	// Read mux
	// ----------------------------------------------------------------
	// With both device-select bits set, reads show the I path
	always_comb begin
		rd_byte = 8'h00;
		case (kind)
			PFC_REG_DEVSEL: rd_byte = {6'h00, devsel_q};
			PFC_REG_MODE: begin
				if (devsel_q[0]) rd_byte = {5'h00, i_cfg_q.mode};
				else if (devsel_q[1]) rd_byte = {5'h00, q_cfg_q.mode};
			end
			PFC_REG_GAIN: begin
				if (devsel_q[0]) rd_byte = {1'b0, i_cfg_q.y_gain, 1'b0, i_cfg_q.x_gain};
				else if (devsel_q[1]) rd_byte = {1'b0, q_cfg_q.y_gain, 1'b0, q_cfg_q.x_gain};
			end
			PFC_REG_STATUS: rd_byte = {6'h00, pair_ok_q, ready_q};
			PFC_REG_XCOEF, PFC_REG_YCOEF: begin
				if (devsel_q[0]) rd_byte = rd_byte_i;
				else if (devsel_q[1]) rd_byte = rd_byte_q;
			end
			PFC_REG_DELAY: begin
				if (devsel_q[0]) rd_byte = {2'h0, sh_delay_q};
			end
			default: rd_byte = 8'h00;
		endcase
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		devsel_d    = devsel_q;
		i_cfg_d     = i_cfg_q;
		q_cfg_d     = q_cfg_q;
		sh_delay_d  = sh_delay_q;
		act_delay_d = act_delay_q;
		xfer_d      = 1'b0;
		gpio_prev_d = xfer_gpio;
		pwrup_cnt_d = pwrup_cnt_q;
		pready_d    = 1'b0;
		pslverr_d   = 1'b0;
		prdata_d    = prdata_q;

		// One wait state: data and error are captured in the first access cycle
		if (access) begin
			pready_d  = 1'b1;
			pslverr_d = kind == PFC_REG_NONE;
			prdata_d  = {24'h000000, rd_byte};
		end

		if (commit) begin
			case (kind)
				PFC_REG_DEVSEL: devsel_d = wbyte[1:0];
				PFC_REG_XFER: xfer_d = wbyte == PFC_XFER_GO;
				PFC_REG_MODE: begin
					if (devsel_q[0]) i_cfg_d.mode = wbyte[2:0];
					if (devsel_q[1]) q_cfg_d.mode = wbyte[2:0];
					pwrup_cnt_d = PFC_PWRUP_W'(PFC_PWRUP_CYC);
				end
				PFC_REG_GAIN: begin
					if (devsel_q[0]) begin
						i_cfg_d.y_gain = wbyte[6:4];
						i_cfg_d.x_gain = wbyte[2:0];
					end
					if (devsel_q[1]) begin
						q_cfg_d.y_gain = wbyte[6:4];
						q_cfg_d.x_gain = wbyte[2:0];
					end
				end
				PFC_REG_DELAY: begin
					// Out-of-range delays saturate at the longest tap
					if (devsel_q[0]) begin
						sh_delay_d = (wbyte > {2'h0, PFC_DELAY_MAX}) ? PFC_DELAY_MAX
							: wbyte[5:0];
					end
				end
				default: devsel_d = devsel_q;
			endcase
		end

		// GPIO transfer is rising-edge triggered; both sources merge into one pulse
		if (xfer_gpio && !gpio_prev_q) xfer_d = 1'b1;
		if (xfer_q) act_delay_d = sh_delay_q;

		if (!commit || kind != PFC_REG_MODE) begin
			if (pwrup_cnt_q != '0) pwrup_cnt_d = pwrup_cnt_q - 1'b1;
		end
	end

	// Illegal pairs only flag status; coefficient storage is untouched
	assign ready_d   = pwrup_cnt_d == '0;
	assign pair_ok_d = pair_legal(i_cfg_d.mode, q_cfg_d.mode)
		&& pair_legal(q_cfg_d.mode, i_cfg_d.mode);

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			devsel_q    <= PFC_DEVSEL_RST;
			i_cfg_q     <= '0;
			q_cfg_q     <= '0;
			sh_delay_q  <= PFC_DELAY_RST;
			act_delay_q <= PFC_DELAY_RST;
			xfer_q      <= 1'b0;
			gpio_prev_q <= 1'b0;
			pwrup_cnt_q <= '0;
			ready_q     <= 1'b1;
			pair_ok_q   <= 1'b1;
			pready_q    <= 1'b0;
			pslverr_q   <= 1'b0;
			prdata_q    <= 32'h00000000;
		end else if (pce) begin
			devsel_q    <= devsel_d;
			i_cfg_q     <= i_cfg_d;
			q_cfg_q     <= q_cfg_d;
			sh_delay_q  <= sh_delay_d;
			act_delay_q <= act_delay_d;
			xfer_q      <= xfer_d;
			gpio_prev_q <= gpio_prev_d;
			pwrup_cnt_q <= pwrup_cnt_d;
			ready_q     <= ready_d;
			pair_ok_q   <= pair_ok_d;
			pready_q    <= pready_d;
			pslverr_q   <= pslverr_d;
			prdata_q    <= prdata_d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign prdata              = prdata_q;
	assign pready              = pready_q;
	assign pslverr             = pslverr_q;
	assign i_path_filter_sel   = i_cfg_q.mode;
	assign q_path_filter_sel   = q_cfg_q.mode;
	assign i_path_cfg          = i_cfg_q;
	assign q_path_cfg          = q_cfg_q;
	assign half_cplx_tap_delay = act_delay_q;
	assign coef_xfer           = xfer_q;
	assign filter_ready        = ready_q;
	assign mode_pair_ok        = pair_ok_q;

endmodule : pfc_fir_config

// file: design/pfc_pkg.sv
// Shared constants and types for the programmable FIR configuration block
package pfc_pkg;

	// ----------------------------------------------------------------
	// Geometry
	// ----------------------------------------------------------------
	localparam int PFC_TAPS   = 24;
	localparam int PFC_TAP_W  = 5;
	localparam int PFC_COEF_W = 16;
	localparam int PFC_IDX_W  = 12;
	localparam int PFC_ADDR_W = 14;

	// ----------------------------------------------------------------
	// Register indices (byte address = 4 * index)
	// ----------------------------------------------------------------
	localparam logic [11:0] PFC_IDX_DEVSEL   = 12'h008;
	localparam logic [11:0] PFC_IDX_XFER     = 12'h00f;
	localparam logic [11:0] PFC_IDX_MODE     = 12'hdf8;
	localparam logic [11:0] PFC_IDX_GAIN     = 12'hdf9;
	localparam logic [11:0] PFC_IDX_STATUS   = 12'hdfa;
	localparam logic [11:0] PFC_IDX_XCOEF    = 12'he00;
	localparam logic [11:0] PFC_IDX_XCOEF_LO = 12'he2f;
	localparam logic [11:0] PFC_IDX_YCOEF    = 12'hf00;
	localparam logic [11:0] PFC_IDX_YCOEF_LO = 12'hf2f;
	localparam logic [11:0] PFC_IDX_DELAY    = 12'hf30;

	// ----------------------------------------------------------------
	// Field values and reset values
	// ----------------------------------------------------------------
	localparam logic [1:0] PFC_SEL_I      = 2'h1;
	localparam logic [1:0] PFC_SEL_Q      = 2'h2;
	localparam logic [7:0] PFC_XFER_GO    = 8'h01;
	localparam logic [2:0] PFC_MODE_BYP   = 3'h0;
	localparam logic [2:0] PFC_MODE_R24   = 3'h1;
	localparam logic [2:0] PFC_MODE_R48   = 3'h2;
	localparam logic [2:0] PFC_MODE_CASC  = 3'h4;
	localparam logic [2:0] PFC_MODE_FCPX  = 3'h5;
	localparam logic [2:0] PFC_MODE_HCPX  = 3'h6;
	localparam logic [2:0] PFC_MODE_R96   = 3'h7;
	localparam logic [2:0] PFC_GAIN_M12   = 3'h6;
	localparam logic [2:0] PFC_GAIN_M6    = 3'h7;
	localparam logic [2:0] PFC_GAIN_0     = 3'h0;
	localparam logic [2:0] PFC_GAIN_P6    = 3'h1;
	localparam logic [2:0] PFC_GAIN_P12   = 3'h2;
	localparam logic [5:0] PFC_DELAY_MAX  = 6'h2f;
	localparam logic [1:0] PFC_DEVSEL_RST = 2'h0;
	localparam logic [5:0] PFC_DELAY_RST  = 6'h00;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int PFC_CLK_NS     = 50;
	localparam int PFC_PWRUP_NS   = 5000;
	localparam int PFC_PWRUP_CYC  = (PFC_PWRUP_NS + PFC_CLK_NS - 1) / PFC_CLK_NS;
	localparam int PFC_PWRUP_W    = 8;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [2:0] mode;
		logic [2:0] y_gain;
		logic [2:0] x_gain;
	} pfc_path_cfg_type;

	typedef enum {
		PFC_REG_NONE,
		PFC_REG_DEVSEL,
		PFC_REG_XFER,
		PFC_REG_MODE,
		PFC_REG_GAIN,
		PFC_REG_STATUS,
		PFC_REG_XCOEF,
		PFC_REG_YCOEF,
		PFC_REG_DELAY
	} pfc_reg_type;

endpackage : pfc_pkg
